// *** logic/serial_adc_host_port.sv ***
// serial host port, power modes and result buffer of a 12-bit sampling converter
// assumes the host drives serial_clk and convert_start_strobe together, and that
// analog_level is the quantised input presented in the clk domain
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// result fifo, core clock domain
module result_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr;
    logic [PTR_W-1:0]            rd;
    logic [CNT_W-1:0]            cnt;
  } fifo_s;

  fifo_s f_reg;
  fifo_s f_next;
  logic  do_wr;
  logic  do_rd;

  // honest flags straight from the occupancy count
  assign in_ready  = (f_reg.cnt != CNT_FULL);
  assign out_valid = (f_reg.cnt != '0);
  assign out_data  = f_reg.mem[f_reg.rd];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // pointer wrap is explicit so depth need not be a power of two
  always_comb begin
    f_next = f_reg;
    if (do_wr) begin
      f_next.mem[f_reg.wr] = in_data;
      f_next.wr = (f_reg.wr == PTR_LAST) ? '0 : f_reg.wr + 1'b1;
    end
    if (do_rd) begin
      f_next.rd = (f_reg.rd == PTR_LAST) ? '0 : f_reg.rd + 1'b1;
    end
    if (do_wr && !do_rd) begin
      f_next.cnt = f_reg.cnt + 1'b1;
    end else if (do_rd && !do_wr) begin
      f_next.cnt = f_reg.cnt - 1'b1;
    end
  end

  // storage is not cleared, only the pointers and count
  always_ff @(posedge clk) begin
    if (srst) begin
      f_reg.mem <= f_next.mem;
      f_reg.wr  <= '0;
      f_reg.rd  <= '0;
      f_reg.cnt <= '0;
    end else begin
      f_reg <= f_next;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// top: power control and conversion on clk, frame shifter on serial_clk
module serial_adc_host_port (
  // core clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // host link
  input  wire logic        serial_clk,
  input  wire logic        convert_start_strobe,
  output logic             serial_data_out,
  // converter core side
  input  wire logic [11:0] analog_level,
  input  wire logic        bipolar_mode,
  output logic             sample_hold,
  // power and reference status
  output logic             light_standby_mode,
  output logic             deep_standby_mode,
  output logic             reference_ready_flag
);

  typedef struct packed {
    logic                 convert_start_strobe_s1;
    logic                 convert_start_strobe_s2;
    logic                 convert_start_strobe_d;
    logic                 sclk_s1;
    logic                 sclk_s2;
    logic                 sclk_d;
    logic                 bip_s1;
    logic                 bip_s2;
    logic                 ack_s1;
    logic                 ack_s2;
    adc_port_pkg::convert_start_strobe_e  cstate;
    logic [5:0]           ccnt;
    logic [11:0]          held;
    logic                 hold;
    adc_port_pkg::power_e pwr;
    logic [2:0]           pulses;
    logic                 ref_ready;
    logic [10:0]          rcnt;
    logic                 req;
    logic [12:0]          xfer;
  } core_s;

  typedef struct packed {
    logic        rst_s1;
    logic        rst_s2;
    logic        convert_start_strobe_d;
    logic        req_s1;
    logic        req_s2;
    logic        ack;
    logic        full;
    logic        act;
    logic [12:0] word;
    logic [12:0] shift;
    logic [3:0]  cnt;
  } link_s;

  core_s       c_reg;
  core_s       c_next;
  link_s       lk_reg;
  link_s       lk_next;
  logic        dout_reg;
  logic        convert_start_strobe_rise;
  logic [5:0]  acq_cnt;
  logic        xfer_busy;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic [12:0] fifo_in_data;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [12:0] fifo_out_data;
  logic        convert_start_strobe_edge;
  logic        sclk_seen;

  //////////////////////////////////////////////////////////////////////////////
  // core domain

  // strobe edge is seen only after the two-stage synchroniser
  assign convert_start_strobe_rise      = c_reg.convert_start_strobe_s2 && !c_reg.convert_start_strobe_d;
  assign acq_cnt        = c_reg.bip_s2 ? adc_port_pkg::ACQ_BI_CNT : adc_port_pkg::ACQ_UNI_CNT;
  assign xfer_busy      = (c_reg.req != c_reg.ack_s2);
  assign fifo_in_valid  = (c_reg.cstate == adc_port_pkg::CONVERT_START_STROBE_BUSY) && (c_reg.ccnt == '0);
  assign fifo_in_data   = {c_reg.ref_ready, c_reg.held};
  assign fifo_out_ready = !xfer_busy;
  assign sclk_seen      = (c_reg.sclk_s2 != c_reg.sclk_d);

  result_fifo #(
    .WIDTH (adc_port_pkg::FRAME_BITS),
    .DEPTH (adc_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // power modes, reference charge, conversion and word hand-off
  always_comb begin
    c_next         = c_reg;
    c_next.convert_start_strobe_s1 = convert_start_strobe;
    c_next.convert_start_strobe_s2 = c_reg.convert_start_strobe_s1;
    c_next.convert_start_strobe_d  = c_reg.convert_start_strobe_s2;
    c_next.sclk_s1 = lk_reg.act;
    c_next.sclk_s2 = c_reg.sclk_s1;
    c_next.sclk_d  = c_reg.sclk_s2;
    c_next.bip_s1  = bipolar_mode;
    c_next.bip_s2  = c_reg.bip_s1;
    c_next.ack_s1  = lk_reg.ack;
    c_next.ack_s2  = c_reg.ack_s1;
    // any clock activity breaks a pulse run and wakes the part
    if (sclk_seen) begin
      c_next.pulses = '0;
      c_next.pwr    = adc_port_pkg::PWR_NORMAL;
      if (c_reg.pwr == adc_port_pkg::PWR_DEEP) begin
        c_next.rcnt      = adc_port_pkg::REF_CNT_INIT;
        c_next.ref_ready = 1'b0;
      end
    end else if (convert_start_strobe_rise && c_reg.pulses != adc_port_pkg::DEEP_PULSES) begin
      c_next.pulses = c_reg.pulses + 1'b1;
      if (c_next.pulses == adc_port_pkg::LIGHT_PULSES) begin
        c_next.pwr = adc_port_pkg::PWR_LIGHT;
      end
      if (c_next.pulses == adc_port_pkg::DEEP_PULSES) begin
        c_next.pwr       = adc_port_pkg::PWR_DEEP;
        c_next.ref_ready = 1'b0;
      end
    end
    // reference keeps its charge in light standby, so the flag survives it
    if (c_reg.pwr == adc_port_pkg::PWR_NORMAL && !c_reg.ref_ready) begin
      if (c_reg.rcnt == '0) begin
        c_next.ref_ready = 1'b1;
      end else begin
        c_next.rcnt = c_reg.rcnt - 1'b1;
      end
    end
    // a full fifo stalls the finished conversion and so blocks new samples
    unique case (c_reg.cstate)
      adc_port_pkg::CONVERT_START_STROBE_IDLE: begin
        if (convert_start_strobe_rise && c_reg.pwr == adc_port_pkg::PWR_NORMAL) begin
          c_next.held   = analog_level;
          c_next.ccnt   = adc_port_pkg::CONVERT_START_STROBE_CNT_INIT;
          c_next.cstate = adc_port_pkg::CONVERT_START_STROBE_BUSY;
        end
      end
      adc_port_pkg::CONVERT_START_STROBE_BUSY: begin
        if (c_reg.ccnt != '0) begin
          c_next.ccnt = c_reg.ccnt - 1'b1;
        end else if (fifo_in_ready) begin
          c_next.cstate = adc_port_pkg::CONVERT_START_STROBE_IDLE;
        end
      end
    endcase
    // hold drops early: tracking overlaps the tail of the conversion
    c_next.hold = (c_next.cstate == adc_port_pkg::CONVERT_START_STROBE_BUSY) && (c_next.ccnt > acq_cnt);
    // bundled data: xfer stays put until the link acknowledges
    if (fifo_out_valid && !xfer_busy) begin
      c_next.xfer = fifo_out_data;
      c_next.req  = !c_reg.req;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      c_reg           <= c_next;
      c_reg.cstate    <= adc_port_pkg::CONVERT_START_STROBE_IDLE;
      c_reg.ccnt      <= '0;
      c_reg.held      <= adc_port_pkg::HELD_RESET;
      c_reg.hold      <= 1'b0;
      c_reg.pwr       <= adc_port_pkg::PWR_NORMAL;
      c_reg.pulses    <= '0;
      c_reg.ref_ready <= 1'b0;
      c_reg.rcnt      <= adc_port_pkg::REF_CNT_INIT;
      c_reg.req       <= 1'b0;
      c_reg.xfer      <= adc_port_pkg::WORD_RESET;
      c_reg.convert_start_strobe_d    <= 1'b0;
    end else begin
      c_reg <= c_next;
    end
  end

  assign sample_hold          = c_reg.hold;
  assign light_standby_mode   = (c_reg.pwr == adc_port_pkg::PWR_LIGHT);
  assign deep_standby_mode    = (c_reg.pwr == adc_port_pkg::PWR_DEEP);
  assign reference_ready_flag = c_reg.ref_ready;

  capture_a: assert property (@(posedge clk) disable iff (srst)
    (convert_start_strobe_rise && c_reg.cstate == adc_port_pkg::CONVERT_START_STROBE_IDLE &&
     c_reg.pwr == adc_port_pkg::PWR_NORMAL)
    |=> (c_reg.held == $past(analog_level) && c_reg.cstate == adc_port_pkg::CONVERT_START_STROBE_BUSY))
    else $error("input not captured on convert start");

  early_track_a: assert property (@(posedge clk) disable iff (srst)
    $fell(c_reg.hold) |-> (c_reg.cstate == adc_port_pkg::CONVERT_START_STROBE_BUSY && c_reg.ccnt == acq_cnt))
    else $error("acquisition did not overlap the conversion tail");

  light_entry_a: assert property (@(posedge clk) disable iff (srst)
    (convert_start_strobe_rise && !sclk_seen && c_reg.pulses == 3'h1) |=> light_standby_mode)
    else $error("second pulse with clock low did not enter light standby");

  deep_entry_a: assert property (@(posedge clk) disable iff (srst)
    (convert_start_strobe_rise && !sclk_seen && c_reg.pulses == 3'h3) |=> deep_standby_mode)
    else $error("fourth pulse with clock low did not enter deep standby");

  wake_a: assert property (@(posedge clk) disable iff (srst)
    (c_reg.pwr != adc_port_pkg::PWR_NORMAL && sclk_seen)
    |=> (!light_standby_mode && !deep_standby_mode))
    else $error("clock activity did not wake the part");

  light_ready_a: assert property (@(posedge clk) disable iff (srst)
    (light_standby_mode && reference_ready_flag) |=> (reference_ready_flag || deep_standby_mode))
    else $error("ready flag lost across light standby");

  deep_ready_a: assert property (@(posedge clk) disable iff (srst)
    deep_standby_mode |-> !reference_ready_flag)
    else $error("ready flag high in deep standby");

  charge_done_a: assert property (@(posedge clk) disable iff (srst)
    (c_reg.pwr == adc_port_pkg::PWR_NORMAL && !c_reg.ref_ready && c_reg.rcnt == '0)
    |=> reference_ready_flag)
    else $error("ready flag not raised when charge completed");

  //////////////////////////////////////////////////////////////////////////////
  // link domain, clocked by the host serial clock

  // strobe is generated with serial_clk, so it is sampled on that clock directly
  assign convert_start_strobe_edge = convert_start_strobe && !lk_reg.convert_start_strobe_d;

  // frame shifter and receiving side of the word hand-off
  always_comb begin
    lk_next        = lk_reg;
    lk_next.rst_s1 = srst;
    lk_next.rst_s2 = lk_reg.rst_s1;
    lk_next.convert_start_strobe_d = convert_start_strobe;
    lk_next.req_s1 = c_reg.req;
    lk_next.req_s2 = lk_reg.req_s1;
    // one toggle per rising edge, so even a lone short clock pulse reaches the core
    lk_next.act    = !lk_reg.act;
    // with no fresh word a frame repeats the last one
    if (convert_start_strobe_edge) begin
      lk_next.shift = lk_reg.word;
      lk_next.cnt   = adc_port_pkg::FRAME_CNT_INIT;
      lk_next.full  = 1'b0;
    end else if (lk_reg.cnt != '0) begin
      lk_next.shift = {lk_reg.shift[11:0], 1'b0};
      lk_next.cnt   = lk_reg.cnt - 1'b1;
    end
    // load after the frame start, so a word arriving then stays marked full
    if (lk_reg.req_s2 != lk_reg.ack && !lk_reg.full) begin
      lk_next.word = c_reg.xfer;
      lk_next.full = 1'b1;
      lk_next.ack  = lk_reg.req_s2;
    end
  end

  // link state only resets while serial_clk runs
  always_ff @(posedge serial_clk) begin
    if (lk_reg.rst_s2) begin
      lk_reg        <= lk_next;
      lk_reg.convert_start_strobe_d <= 1'b1;
      lk_reg.ack    <= lk_next.req_s2;
      lk_reg.full   <= 1'b0;
      lk_reg.act    <= 1'b0;
      lk_reg.word   <= adc_port_pkg::WORD_RESET;
      lk_reg.shift  <= adc_port_pkg::WORD_RESET;
      lk_reg.cnt    <= '0;
    end else begin
      lk_reg <= lk_next;
    end
  end

  // data changes on falling edges, half a clock after the shift
  always_ff @(negedge serial_clk) begin
    if (lk_reg.rst_s2) begin
      dout_reg <= 1'b0;
    end else if (lk_reg.cnt != '0) begin
      dout_reg <= lk_reg.shift[12];
    end
  end

  assign serial_data_out = dout_reg;

  first_bit_a: assert property (@(posedge serial_clk) disable iff (lk_reg.rst_s2)
    convert_start_strobe_edge |=> (serial_data_out == $past(lk_reg.word[12])))
    else $error("ready flag not on the line after convert start");

  bit_order_a: assert property (@(posedge serial_clk) disable iff (lk_reg.rst_s2)
    (!convert_start_strobe_edge && lk_reg.cnt > 4'h1) |=> (serial_data_out == $past(lk_reg.shift[11])))
    else $error("result bits out of order");

  frame_len_a: assert property (@(posedge serial_clk) disable iff (lk_reg.rst_s2)
    (convert_start_strobe_edge ##1 !convert_start_strobe_edge [*8]) |-> (lk_reg.cnt == 4'h6))
    else $error("frame counter not one bit per clock");

  line_steady_a: assert property (@(posedge serial_clk) disable iff (lk_reg.rst_s2)
    (lk_reg.cnt == '0 && !convert_start_strobe_edge) |=> $stable(serial_data_out))
    else $error("data line moved after the last bit");

endmodule

// *** logic/adc_port_pkg.sv ***
// constants and types shared by the serial converter host port
// assumes a 20 mhz core clock and a host serial clock on a separate domain
package adc_port_pkg;

  // clock and frame layout
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESULT_BITS   = 12;
  localparam int FRAME_BITS    = 13;
  localparam int FIFO_DEPTH    = 8;

  // conversion and acquisition times, in ns, and derived cycle counts
  localparam int CONVERT_START_STROBE_NS        = 2000;
  localparam int CONVERT_START_STROBE_CYCLES    = (CONVERT_START_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_UNI_NS     = 300;
  localparam int ACQ_BI_NS      = 270;
  localparam int ACQ_UNI_CYCLES = ACQ_UNI_NS / CLK_PERIOD_NS;
  localparam int ACQ_BI_CYCLES  = ACQ_BI_NS / CLK_PERIOD_NS;
  localparam int REF_CHARGE_NS  = 100000;
  localparam int REF_CYCLES     = (REF_CHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // counter loads at the widths of the counters they meet
  localparam logic [5:0]  CONVERT_START_STROBE_CNT_INIT  = 6'(CONVERT_START_STROBE_CYCLES);
  localparam logic [5:0]  ACQ_UNI_CNT    = 6'(ACQ_UNI_CYCLES);
  localparam logic [5:0]  ACQ_BI_CNT     = 6'(ACQ_BI_CYCLES);
  localparam logic [10:0] REF_CNT_INIT   = 11'(REF_CYCLES);
  localparam logic [3:0]  FRAME_CNT_INIT = 4'(FRAME_BITS);
  localparam logic [2:0]  LIGHT_PULSES   = 3'h2;
  localparam logic [2:0]  DEEP_PULSES    = 3'h4;

  // reset values
  localparam logic [12:0] WORD_RESET = 13'h0000;
  localparam logic [11:0] HELD_RESET = 12'h000;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_LIGHT  = 2'b01,
    PWR_DEEP   = 2'b10
  } power_e;

  typedef enum logic {
    CONVERT_START_STROBE_IDLE = 1'b0,
    CONVERT_START_STROBE_BUSY = 1'b1
  } convert_start_strobe_e;

endpackage

// *** verif/adc_host_model.sv ***
// host model: gated serial clock, convert start strobe and frame capture
// assumes the port shifts on falling edges; the clock rests low outside frames
`timescale 1ns/1ps
module adc_host_model (
  // host link
  output logic      serial_clk,
  output logic      convert_start_strobe,
  input  wire logic serial_data_out
);
  logic run_reg;

  initial begin
    serial_clk = 1'b0;
    convert_start_strobe = 1'b0;
    run_reg = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // the host owns the clock; it only toggles while a transfer is wanted
  always begin
    #7.5;
    if (run_reg) serial_clk = ~serial_clk;
    else serial_clk = 1'b0;
  end

  // n clock pulses with the strobe low, then the clock stops low
  task automatic ticks(input int n);
    run_reg = 1'b1;
    repeat (n) @(posedge serial_clk);
    @(negedge serial_clk);
    run_reg = 1'b0;
  endtask

  // one frame: strobe rises just after a clock rise, 13 bits read on rises
  task automatic frame(output logic [12:0] word, output logic steady);
    run_reg = 1'b1;
    @(posedge serial_clk);
    convert_start_strobe <= 1'b1;
    @(posedge serial_clk);
    for (int i = 12; i >= 0; i--) begin
      @(posedge serial_clk);
      word[i] = serial_data_out;
      if (i == 5) convert_start_strobe <= 1'b0;
    end
    steady = 1'b1;
    // a few more clocks without a new edge must not move the line
    repeat (3) begin
      @(posedge serial_clk);
      if (serial_data_out !== word[0]) steady = 1'b0;
    end
    @(negedge serial_clk);
    run_reg = 1'b0;
  endtask

  // strobe pulses with the clock idle low; wide enough for the 2ff sampler
  task automatic pulses(input int n);
    repeat (n) begin
      #200 convert_start_strobe = 1'b1;
      #200 convert_start_strobe = 1'b0;
    end
  endtask
endmodule

// *** verif/serial_adc_host_port_test.sv ***
// self-checking bench for the serial converter host port
// assumes adc_host_model plays the host and the package reference charge time
`timescale 1ns/1ps
module serial_adc_host_port_test;
  logic        clk          = 1'b0;
  logic        srst         = 1'b1;
  logic [11:0] analog_level = 12'h000;
  logic        bipolar_mode = 1'b0;
  wire         serial_clk;
  wire         convert_start_strobe;
  wire         serial_data_out;
  wire         sample_hold;
  wire         light_standby_mode;
  wire         deep_standby_mode;
  wire         reference_ready_flag;
  int          n_mismatch   = 0;
  int          n_compared   = 0;

  always #25 clk = ~clk;

  serial_adc_host_port uut (
    .clk(clk), .srst(srst), .serial_clk(serial_clk),
    .convert_start_strobe(convert_start_strobe), .serial_data_out(serial_data_out),
    .analog_level(analog_level), .bipolar_mode(bipolar_mode), .sample_hold(sample_hold),
    .light_standby_mode(light_standby_mode), .deep_standby_mode(deep_standby_mode),
    .reference_ready_flag(reference_ready_flag)
  );

  adc_host_model host (
    .serial_clk(serial_clk), .convert_start_strobe(convert_start_strobe),
    .serial_data_out(serial_data_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // comparison and closing
  task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // bounded wait for the reference flag, in clk cycles
  task automatic wait_flag(output int c);
    c = 0;
    while (reference_ready_flag !== 1'b1 && c < 3000) begin
      @(negedge clk);
      c++;
    end
  endtask

  // width of the hold pulse; input is moved once held to prove the capture instant
  task automatic hold_width(input logic [11:0] alt, output int w);
    int t;
    w = 0;
    t = 0;
    while (sample_hold !== 1'b1 && t < 400) begin
      @(negedge clk);
      t++;
    end
    @(posedge clk);
    analog_level <= alt;
    while (sample_hold === 1'b1 && w < 100) begin
      @(negedge clk);
      w++;
    end
  endtask

  // n frames, each after enough time for the last conversion to finish
  task automatic frames(input int n, output logic [12:0] w);
    logic st;
    repeat (n) begin
      repeat (80) @(posedge clk);
      host.frame(w, st);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_reference;
    int c;
    wait_flag(c);
    check("charge", 13'(c >= adc_port_pkg::REF_CYCLES - 3 && c <= adc_port_pkg::REF_CYCLES + 5),
          13'h0001);
    $display("test reference done");
  endtask

  // three conversions, unipolar, bipolar, unipolar; frames lag one result
  task automatic test_frames;
    logic [11:0] lv [3] = '{12'ha5c, 12'h3a1, 12'hfff};
    logic [12:0] w;
    logic        st;
    int          hw;
    int          acq;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      analog_level <= lv[k];
      bipolar_mode <= (k == 1);
      repeat (6) @(posedge clk);
      fork
        host.frame(w, st);
        hold_width(~lv[k], hw);
      join
      acq = (k == 1) ? adc_port_pkg::ACQ_BI_CYCLES : adc_port_pkg::ACQ_UNI_CYCLES;
      check("hold", 13'(hw), 13'(adc_port_pkg::CONVERT_START_STROBE_CYCLES - acq));
      check("steady", 13'(st), 13'h0001);
      if (k > 0) check("frame", w, {1'b1, lv[k-1]});
      repeat (80) @(posedge clk);
      // idle clocks with the strobe low let the finished result cross to the link
      host.ticks(4);
    end
    $display("test frames done");
  endtask

  task automatic test_light;
    logic [12:0] w;
    host.pulses(2);
    repeat (10) @(negedge clk);
    check("light", {11'h0, deep_standby_mode, light_standby_mode}, 13'h0001);
    host.ticks(1);
    repeat (6) @(negedge clk);
    check("wake", {10'h0, reference_ready_flag, deep_standby_mode, light_standby_mode},
          13'h0004);
    frames(2, w);
    check("light frame", w, {1'b1, 12'h000});
    $display("test light done");
  endtask

  task automatic test_deep;
    logic [12:0] w;
    int          c;
    host.pulses(4);
    repeat (10) @(negedge clk);
    check("deep", {11'h0, deep_standby_mode, light_standby_mode}, 13'h0002);
    host.ticks(1);
    repeat (6) @(negedge clk);
    check("wake", {10'h0, reference_ready_flag, deep_standby_mode, light_standby_mode},
          13'h0000);
    frames(3, w);
    check("charging", 13'(w[12]), 13'h0000);
    wait_flag(c);
    check("recharge", 13'(c > 100 && c < 3000), 13'h0001);
    // a backlog word sits ahead, so the third frame shows the first flagged sample
    frames(3, w);
    check("ready", 13'(w[12]), 13'h0001);
    $display("test deep done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need about 5000 clk cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report;
  end

  // main sequence; the link clock runs during reset so the link side resets too
  initial begin
    fork
      host.ticks(6);
      repeat (12) @(posedge clk);
    join
    srst <= 1'b0;
    // the link side leaves its reset only on serial clock edges
    host.ticks(4);
    @(negedge clk);
    check("reset", {9'h0, sample_hold, light_standby_mode, deep_standby_mode,
          reference_ready_flag}, 13'h0000);
    test_reference;
    test_frames;
    test_light;
    test_deep;
    final_report;
  end
endmodule
